// ### bench/pfs_ext_mem.sv
// pfs_ext_mem: external code/data memory with address latch
// assumes: pins of pfs_top; answers under a read strobe, echoes a driven port, else scrambles
`timescale 1ns/1ps
`default_nettype none
module pfs_ext_mem (
   input wire logic        clock,
   input wire logic [7:0]  port_out,
   input wire logic        port_oe,
   input wire logic [7:0]  high_port,
   input wire logic        high_oe,
   input wire logic        ale,
   input wire logic        prd_n,
   input wire logic        drd_n,
   input wire logic        dwr_n,
   output logic [7:0]      port_in,
   output logic [15:0]     last_addr,
   output logic [7:0]      last_wdata
);
   logic [7:0]  lat_q;
   logic [7:0]  prev_q;
   logic [15:0] addr;
   // low byte taken while the latch pulse stands; a clocked capture
   // avoids racing the port as it turns over at the closing edge
   always @(posedge clock)
      if (ale)
         lat_q <= port_out;
   assign addr = {high_oe ? high_port : 8'h00, lat_q};
   // one store for code and data, read strobes merged
   always_comb begin
      if (port_oe)
         port_in = port_out;
      else if (!(prd_n && drd_n))
         port_in = addr[7:0] ^ addr[15:8] ^ 8'hc3;
      else
         port_in = ~prev_q; // released bus never keeps its last value
   end
   always @(posedge clock) prev_q <= port_in;
   always @(posedge clock)
      if (!(prd_n && drd_n && dwr_n))
         last_addr <= addr;
   always @(posedge clock)
      if (!dwr_n)
         last_wdata <= port_out;
endmodule
`default_nettype wire

// ### bench/pfs_props.sv
// pfs_props: pin timing, reset pc, vector and power relations of the fetch and bus engine
// assumes: bound to pfs_top, single clock, nrst async active low
`timescale 1ns/1ps
`default_nettype none
module pfs_props (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        done,
   input wire logic        irq_take,
   input wire logic [1:0]  irq_src,
   input wire logic [15:0] vec_addr,
   input wire logic [15:0] reset_pc,
   input wire logic        cpu_clk_en,
   input wire logic        periph_clk_en,
   input wire logic        ports_bus_owned,
   input wire logic        muxed_addr_data_port_oe,
   input wire logic        high_addr_port_oe,
   input wire logic        addr_latch_en,
   input wire logic        program_read_strobe_n,
   input wire logic        data_read_strobe_n,
   input wire logic        data_write_strobe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // ----------
   // relations
   // ----------
   a_reset_pc_zero: assert property (reset_pc == 16'h0000)
      else $error("reset pc not zero");
   a_vector_table: assert property (irq_take |=>
      vec_addr == (16'h0003 + {11'h000, $past(irq_src), 3'h0}))
      else $error("vector address wrong");
   a_pstrb_bus_owned: assert property (!program_read_strobe_n |->
      ports_bus_owned && high_addr_port_oe)
      else $error("program strobe without bus ownership");
   a_port_floats: assert property (!(program_read_strobe_n && data_read_strobe_n) |->
      !muxed_addr_data_port_oe)
      else $error("port driven during read strobe");
   a_ale_drives: assert property (addr_latch_en |-> muxed_addr_data_port_oe)
      else $error("latch pulse while port floats");
   a_ale_to_strb: assert property ($rose(addr_latch_en) |-> ##[2:4]
      !(program_read_strobe_n && data_read_strobe_n && data_write_strobe_n))
      else $error("no strobe after latch pulse");
   a_pstrb_width: assert property ($fell(program_read_strobe_n) |->
      !program_read_strobe_n [*3] ##1 program_read_strobe_n)
      else $error("program strobe width wrong");
   a_one_strobe: assert property ($onehot0({!program_read_strobe_n,
      !data_read_strobe_n, !data_write_strobe_n}))
      else $error("two strobes at once");
   a_write_drives: assert property (!data_write_strobe_n |-> muxed_addr_data_port_oe)
      else $error("write strobe with port floating");
   a_done_idle_hi: assert property (done |->
      program_read_strobe_n && data_read_strobe_n && data_write_strobe_n)
      else $error("strobe low at completion");
   a_pdown_all_off: assert property (!periph_clk_en |-> !cpu_clk_en)
      else $error("cpu clocked in power down");
endmodule
`default_nettype wire

// ### bench/testbench.sv
// testbench: directed checks of fetch steering and external bus
// assumes: pfs_top at 16K rom, pfs_ext_mem on its pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
   logic        clock, nrst, req, req_wide, irq_take, idle_req, pdown_req, wake;
   logic        busy, done, cpu_clk_en, periph_clk_en, ports_bus_owned;
   logic        fetch_select_strap_n, muxed_addr_data_port_oe, high_addr_port_oe;
   logic        addr_latch_en, program_read_strobe_n, data_read_strobe_n;
   logic        data_write_strobe_n, p_seen, o_seen, d_seen;
   logic [1:0]  req_kind, irq_src;
   logic [15:0] req_addr, reset_pc, vec_addr, last_addr;
   logic [7:0]  req_wdata, rdata, muxed_addr_data_port_in, muxed_addr_data_port_out;
   logic [7:0]  high_addr_port, last_wdata, rd;
   int          fails, samples_checked, cyc;
   pfs_top dut (
      .clock                    (clock),
      .nrst                     (nrst),
      .req                      (req),
      .req_kind                 (req_kind),
      .req_addr                 (req_addr),
      .req_wide                 (req_wide),
      .req_wdata                (req_wdata),
      .irq_take                 (irq_take),
      .irq_src                  (irq_src),
      .idle_req                 (idle_req),
      .pdown_req                (pdown_req),
      .wake                     (wake),
      .busy                     (busy),
      .done                     (done),
      .rdata                    (rdata),
      .reset_pc                 (reset_pc),
      .vec_addr                 (vec_addr),
      .cpu_clk_en               (cpu_clk_en),
      .periph_clk_en            (periph_clk_en),
      .ports_bus_owned          (ports_bus_owned),
      .fetch_select_strap_n     (fetch_select_strap_n),
      .muxed_addr_data_port_in  (muxed_addr_data_port_in),
      .muxed_addr_data_port_out (muxed_addr_data_port_out),
      .muxed_addr_data_port_oe  (muxed_addr_data_port_oe),
      .high_addr_port           (high_addr_port),
      .high_addr_port_oe        (high_addr_port_oe),
      .addr_latch_en            (addr_latch_en),
      .program_read_strobe_n    (program_read_strobe_n),
      .data_read_strobe_n       (data_read_strobe_n),
      .data_write_strobe_n      (data_write_strobe_n)
   );
   pfs_ext_mem u_mem (
      .clock     (clock),
      .port_out  (muxed_addr_data_port_out),
      .port_oe   (muxed_addr_data_port_oe),
      .high_port (high_addr_port),
      .high_oe   (high_addr_port_oe),
      .ale       (addr_latch_en),
      .prd_n     (program_read_strobe_n),
      .drd_n     (data_read_strobe_n),
      .dwr_n     (data_write_strobe_n),
      .port_in   (muxed_addr_data_port_in),
      .last_addr (last_addr),
      .last_wdata(last_wdata)
   );
   initial begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      if (!program_read_strobe_n) p_seen <= 1;
      if (ports_bus_owned) o_seen <= 1;
      if (!(data_read_strobe_n && data_write_strobe_n)) d_seen <= 1;
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end
   // ----------
   // helpers
   // ----------
   task automatic complete_run();
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic do_reset(input logic s);
      fetch_select_strap_n = s;
      nrst = 0;
      idle(12);
      nrst = 1;
      idle(5); // strap is taken at the third edge, so wait past it
   endtask
   function automatic logic [7:0] ext_b(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hc3;
   endfunction
   task automatic access(input logic [1:0] k, input logic [15:0] a, input logic w,
                         input logic [7:0] wd);
      int n;
      p_seen = 0; o_seen = 0; d_seen = 0;
      req = 1; req_kind = k; req_addr = a; req_wide = w; req_wdata = wd;
      idle(1);
      req = 0;
      n = 0;
      while (done !== 1'b1 && n < 20) begin
         idle(1);
         n++;
      end
      rd = (done === 1'b1) ? rdata : 8'hxx; // a hang leaves x so compares fail
   endtask
   task automatic fetch(input logic [15:0] a, input logic ext);
      access(2'h0, a, 1'b0, 8'h00);
      `CHK(rd, ext ? ext_b(a) : (a[7:0] ^ 8'h5a))
      `CHK(p_seen, ext)
      `CHK(o_seen, ext)
      `CHK(d_seen, 1'b0)
      if (ext) `CHK(last_addr, a)
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_map();
      `CHK(reset_pc, 16'h0000)
      `CHK({program_read_strobe_n, data_read_strobe_n, data_write_strobe_n}, 3'h7)
      fetch(16'h0000, 1'b0);
      fetch(16'h3fff, 1'b0);
      fetch(16'h4000, 1'b1);
      fetch(16'hffff, 1'b1);
      fetch(16'h1000, 1'b0);
   endtask
   task automatic t_data();
      access(2'h2, 16'h8123, 1'b1, 8'ha5);
      `CHK(last_addr, 16'h8123)
      `CHK(last_wdata, 8'ha5)
      `CHK(p_seen, 1'b0)
      access(2'h1, 16'h9abc, 1'b1, 8'h00);
      `CHK(rd, ext_b(16'h9abc))
      access(2'h1, 16'h5542, 1'b0, 8'h00);
      `CHK(last_addr, 16'h0042)
      `CHK(rd, ext_b(16'h0042))
   endtask
   task automatic t_vectors();
      for (int i = 0; i < 4; i++) begin
         irq_src = i[1:0];
         irq_take = 1;
         idle(1);
         irq_take = 0;
         idle(1);
         `CHK(vec_addr, 16'h0003 + 16'(i * 8))
      end
   endtask
   task automatic t_power(input logic dn);
      idle_req = !dn;
      pdown_req = dn;
      idle(1);
      idle_req = 0;
      pdown_req = 0;
      idle(2);
      `CHK({cpu_clk_en, periph_clk_en}, {1'b0, !dn})
      req = 1; // refused while the cpu is stopped
      idle(4);
      req = 0;
      `CHK(busy, 1'b0)
      wake = 1;
      idle(1);
      wake = 0;
      idle(2);
      `CHK({cpu_clk_en, periph_clk_en}, 2'b11)
   endtask
   task automatic t_strap_low();
      do_reset(1'b0);
      fetch(16'h0000, 1'b1);
      fetch(16'h0123, 1'b1);
   endtask
   initial begin
      {req, req_wide, irq_take, idle_req, pdown_req, wake} = '0;
      req_kind = 2'h0; irq_src = 2'h0; req_addr = 16'h0000; req_wdata = 8'h00;
      fails = 0; samples_checked = 0; cyc = 0;
      do_reset(1'b1);
      t_map();
      t_data();
      t_vectors();
      t_power(1'b0);
      t_power(1'b1);
      t_strap_low();
      complete_run();
   end
endmodule
bind pfs_top pfs_props u_props (
   .clock                   (clock),
   .nrst                    (nrst),
   .done                    (done),
   .irq_take                (irq_take),
   .irq_src                 (irq_src),
   .vec_addr                (vec_addr),
   .reset_pc                (reset_pc),
   .cpu_clk_en              (cpu_clk_en),
   .periph_clk_en           (periph_clk_en),
   .ports_bus_owned         (ports_bus_owned),
   .muxed_addr_data_port_oe (muxed_addr_data_port_oe),
   .high_addr_port_oe       (high_addr_port_oe),
   .addr_latch_en           (addr_latch_en),
   .program_read_strobe_n   (program_read_strobe_n),
   .data_read_strobe_n      (data_read_strobe_n),
   .data_write_strobe_n     (data_write_strobe_n)
);
`default_nettype wire

// ### rtl/pfs_pkg.sv
// pfs_pkg: constants for the program fetch steering and external bus block
// assumes: nothing beyond a SystemVerilog compiler
package pfs_pkg;
   // ---------------------------------------------------------------
   // program map
   // ---------------------------------------------------------------
   localparam logic [15:0] RESET_ADDR    = 16'h0000;
   localparam logic [15:0] VEC_EXT0      = 16'h0003;
   localparam logic [15:0] VEC_TMR0      = 16'h000b;
   localparam logic [15:0] VEC_EXT1      = 16'h0013;
   localparam logic [15:0] VEC_TMR1      = 16'h001b;
   localparam logic [15:0] VEC_STEP      = 16'h0008;
   localparam logic [15:0] LIMIT_4K      = 16'h1000;
   localparam logic [15:0] LIMIT_8K      = 16'h2000;
   localparam logic [15:0] LIMIT_16K     = 16'h4000;
   // rom size codes
   localparam logic [1:0]  ROM_NONE      = 2'h0;
   localparam logic [1:0]  ROM_4K        = 2'h1;
   localparam logic [1:0]  ROM_8K        = 2'h2;
   localparam logic [1:0]  ROM_16K       = 2'h3;
   // ---------------------------------------------------------------
   // bus timing, in clock cycles per phase
   // ---------------------------------------------------------------
   localparam logic [3:0]  PH_ADDR_CYC   = 4'h2;
   localparam logic [3:0]  PH_HOLD_CYC   = 4'h1;
   localparam logic [3:0]  PH_STRB_CYC   = 4'h3;
   // edges after reset before the strap sample is a real pin level
   localparam logic [1:0]  STRAP_WAIT_CYC = 2'h2;
   // access kinds
   localparam logic [1:0]  ACC_CODE      = 2'h0;
   localparam logic [1:0]  ACC_DRD       = 2'h1;
   localparam logic [1:0]  ACC_DWR       = 2'h2;
   // power modes
   localparam logic [1:0]  PWR_RUN       = 2'h0;
   localparam logic [1:0]  PWR_IDLE      = 2'h1;
   localparam logic [1:0]  PWR_DOWN      = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_HOLD = 3'b010,
      ST_STRB = 3'b011,
      ST_DONE = 3'b100
   } pfs_state_e;
endpackage

// ### rtl/pfs_rom.sv
// pfs_rom: on-chip read-only program store, registered read data
// assumes: contents fixed at build time by the rom_byte pattern
`timescale 1ns/1ps
`default_nettype none
module pfs_rom #(
   parameter int AW = 14
) (
   input  wire logic          clock,
   input  wire logic [AW-1:0] addr,
   input  wire logic          rd_en,
   output logic [7:0]         rdata
);
   if (AW < 12 || AW > 16) begin
      $error("pfs_rom: AW out of range");
   end
   // no write port: program store is read only
   function automatic logic [7:0] rom_byte(input logic [AW-1:0] a);
      rom_byte = a[7:0] ^ 8'h5a;
   endfunction
   always_ff @(posedge clock) begin
      if (rd_en) begin
         rdata <= rom_byte(addr);
      end
   end
endmodule
`default_nettype wire

// ### rtl/pfs_sync.sv
// pfs_sync: two flip-flop synchroniser for pin levels
// assumes: one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module pfs_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### rtl/pfs_top.sv
// pfs_top: program fetch steering and external memory bus engine
// assumes: the core issues one request at a time and waits for done
// Function
// - first fetch after reset at zero
// - vectors 8 apart: 0003H, 000BH
// - ext1 to 0013H, timer1 to 001BH
// - 4K part: below 1000H internal
// - 8K part: up to 1FFFH internal
// - 16K part: up to 3FFFH internal
// - strap low sends all fetches external
// - program strobe only on external fetches
// - program space read only, 64K max
// - data space separate; data strobes only there
// - data addresses 8-bit or pointer 16-bit
// - port drives low byte, then floats for reads
// - latch pulse while low byte valid
// - high port drives pc high byte
// - external program addresses always 16 bits
// - both ports bus-only during external fetch
// - idle stops cpu, peripherals keep running
// - power-down stops all activity
// - wide data address high byte on port
`timescale 1ns/1ps
`default_nettype none
module pfs_top #(
   parameter logic [1:0] ROM_SIZE = pfs_pkg::ROM_16K
) (
   input  wire logic        clock,
   input  wire logic        nrst,
   // core side
   input  wire logic        req,
   input  wire logic [1:0]  req_kind,
   input  wire logic [15:0] req_addr,
   input  wire logic        req_wide,
   input  wire logic [7:0]  req_wdata,
   input  wire logic        irq_take,
   input  wire logic [1:0]  irq_src,
   input  wire logic        idle_req,
   input  wire logic        pdown_req,
   input  wire logic        wake,
   output logic             busy,
   output logic             done,
   output logic [7:0]       rdata,
   output logic [15:0]      reset_pc,
   output logic [15:0]      vec_addr,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             ports_bus_owned,
   // pins
   input  wire logic        fetch_select_strap_n,
   input  wire logic [7:0]  muxed_addr_data_port_in,
   output logic [7:0]       muxed_addr_data_port_out,
   output logic             muxed_addr_data_port_oe,
   output logic [7:0]       high_addr_port,
   output logic             high_addr_port_oe,
   output logic             addr_latch_en,
   output logic             program_read_strobe_n,
   output logic             data_read_strobe_n,
   output logic             data_write_strobe_n
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // the rom below is 16K deep, so every size code fits it
   if (ROM_SIZE > pfs_pkg::ROM_16K) begin
      $error("pfs_top: bad ROM_SIZE");
   end
   // the answer is read two synchroniser stages behind the pin, so the
   // strobe must stand three cycles for the byte to reach the core
   if (pfs_pkg::PH_STRB_CYC < 4'h3) begin
      $error("pfs_top: strobe phase too short for the pin synchroniser");
   end
   if (pfs_pkg::PH_ADDR_CYC == 4'h0 || pfs_pkg::PH_HOLD_CYC == 4'h0) begin
      $error("pfs_top: address and hold phases need a cycle each");
   end
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [8:0] sync_out;
   pfs_sync #(.W(9)) u_sync (
      .clock (clock),
      .nrst  (nrst),
      .din   ({fetch_select_strap_n, muxed_addr_data_port_in}),
      .dout  (sync_out)
   );
   logic [7:0] port_in_s;
   assign port_in_s = sync_out[7:0];
   // ---------------------------------------------------------------
   // strap capture
   // ---------------------------------------------------------------
   // strap sampled once after reset release; later pin moves are ignored.
   // the synchroniser leaves reset at zero, so the sample waits until
   // both stages hold the real pin level
   logic       strap_q;
   logic       strap_taken_q;
   logic [1:0] strap_wait_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         strap_q       <= 1'b0;
         strap_taken_q <= 1'b0;
         strap_wait_q  <= 2'h0;
      end else if (strap_wait_q != pfs_pkg::STRAP_WAIT_CYC) begin
         strap_wait_q  <= strap_wait_q + 2'h1;
      end else if (!strap_taken_q) begin
         strap_q       <= sync_out[8];
         strap_taken_q <= 1'b1;
      end
   end
   // ---------------------------------------------------------------
   // steering
   // ---------------------------------------------------------------
   function automatic logic is_internal(input logic [15:0] a, input logic strap);
      logic hit;
      hit = 1'b0;
      if (ROM_SIZE == pfs_pkg::ROM_4K) begin
         hit = a < pfs_pkg::LIMIT_4K;
      end else if (ROM_SIZE == pfs_pkg::ROM_8K) begin
         hit = a < pfs_pkg::LIMIT_8K;
      end else if (ROM_SIZE == pfs_pkg::ROM_16K) begin
         hit = a < pfs_pkg::LIMIT_16K;
      end
      is_internal = hit && strap;
   endfunction
   // ---------------------------------------------------------------
   // reset pc and vectors
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reset_pc <= pfs_pkg::RESET_ADDR;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         vec_addr <= 16'h0000;
      end else if (irq_take) begin
         // vectors sit VEC_STEP apart from VEC_EXT0
         case (irq_src)
            2'h0: vec_addr <= pfs_pkg::VEC_EXT0;
            2'h1: vec_addr <= pfs_pkg::VEC_TMR0;
            2'h2: vec_addr <= pfs_pkg::VEC_EXT1;
            default: vec_addr <= pfs_pkg::VEC_TMR1;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // power modes
   // ---------------------------------------------------------------
   logic [1:0] pwr_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= pfs_pkg::PWR_RUN;
      end else if (wake) begin
         pwr_q <= pfs_pkg::PWR_RUN;
      end else if (pdown_req && !busy) begin
         pwr_q <= pfs_pkg::PWR_DOWN;
      end else if (idle_req && !busy) begin
         pwr_q <= pfs_pkg::PWR_IDLE;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cpu_clk_en    <= 1'b1;
         periph_clk_en <= 1'b1;
      end else begin
         cpu_clk_en    <= (pwr_q == pfs_pkg::PWR_RUN);
         periph_clk_en <= (pwr_q != pfs_pkg::PWR_DOWN);
      end
   end
   logic active;
   assign active = (pwr_q == pfs_pkg::PWR_RUN);
   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   pfs_pkg::pfs_state_e st_q;
   logic [3:0]  cnt_q;
   logic [15:0] addr_q;
   logic [1:0]  kind_q;
   logic        wide_q;
   logic        int_q;
   logic [7:0]  wdata_q;
   logic        take;
   // program space has no write path: only code reads reach the rom;
   // nothing is taken before the strap has been read
   assign take = req && active && strap_taken_q && (st_q == pfs_pkg::ST_IDLE);
   logic [7:0] rom_data;
   pfs_rom #(.AW(14)) u_rom (
      .clock (clock),
      .addr  (addr_q[13:0]),
      .rd_en (st_q == pfs_pkg::ST_ADDR && int_q),
      .rdata (rom_data)
   );
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         addr_q  <= 16'h0000;
         kind_q  <= pfs_pkg::ACC_CODE;
         wide_q  <= 1'b0;
         int_q   <= 1'b0;
         wdata_q <= 8'h00;
      end else if (take) begin
         addr_q  <= req_addr;
         kind_q  <= req_kind;
         // code always 16 bits; data wide only via the pointer
         wide_q  <= (req_kind == pfs_pkg::ACC_CODE) || req_wide;
         int_q   <= (req_kind == pfs_pkg::ACC_CODE) && is_internal(req_addr, strap_q);
         wdata_q <= req_wdata;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_q  <= pfs_pkg::ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (st_q)
            pfs_pkg::ST_IDLE: begin
               if (take) begin
                  st_q  <= pfs_pkg::ST_ADDR;
                  cnt_q <= pfs_pkg::PH_ADDR_CYC - 4'h1;
               end
            end
            pfs_pkg::ST_ADDR: begin
               if (int_q) begin
                  st_q <= pfs_pkg::ST_DONE;
               end else if (cnt_q == 4'h0) begin
                  st_q  <= pfs_pkg::ST_HOLD;
                  cnt_q <= pfs_pkg::PH_HOLD_CYC - 4'h1;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            pfs_pkg::ST_HOLD: begin
               if (cnt_q == 4'h0) begin
                  st_q  <= pfs_pkg::ST_STRB;
                  cnt_q <= pfs_pkg::PH_STRB_CYC - 4'h1;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            pfs_pkg::ST_STRB: begin
               if (cnt_q == 4'h0) begin
                  st_q <= pfs_pkg::ST_DONE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: begin
               st_q <= pfs_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // ---------------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------------
   logic ext;
   assign ext = (st_q != pfs_pkg::ST_IDLE) && (st_q != pfs_pkg::ST_DONE) && !int_q;
   // low byte first, then float for reads; writes drive data
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         muxed_addr_data_port_out <= 8'h00;
         muxed_addr_data_port_oe  <= 1'b0;
      end else begin
         muxed_addr_data_port_oe  <= ext && (st_q == pfs_pkg::ST_ADDR ||
                                     kind_q == pfs_pkg::ACC_DWR);
         muxed_addr_data_port_out <= (st_q == pfs_pkg::ST_ADDR) ?
                                     addr_q[7:0] : wdata_q;
      end
   end
   // latch pulse over the address phase; high byte over the whole of a 16-bit access
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         addr_latch_en     <= 1'b0;
         high_addr_port    <= 8'h00;
         high_addr_port_oe <= 1'b0;
      end else begin
         addr_latch_en     <= ext && (st_q == pfs_pkg::ST_ADDR);
         high_addr_port    <= addr_q[15:8];
         high_addr_port_oe <= ext && wide_q;
      end
   end
   // an 8-bit data access leaves the high port to general i/o
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ports_bus_owned <= 1'b0;
      end else begin
         ports_bus_owned <= ext && kind_q == pfs_pkg::ACC_CODE;
      end
   end
   // strobes idle high and fire only in the strobe phase; a shared
   // code/data memory may AND the two read strobes externally
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         program_read_strobe_n <= 1'b1;
         data_read_strobe_n    <= 1'b1;
         data_write_strobe_n   <= 1'b1;
      end else begin
         program_read_strobe_n <= !(ext && st_q == pfs_pkg::ST_STRB &&
                                    kind_q == pfs_pkg::ACC_CODE);
         data_read_strobe_n    <= !(ext && st_q == pfs_pkg::ST_STRB &&
                                    kind_q == pfs_pkg::ACC_DRD);
         data_write_strobe_n   <= !(ext && st_q == pfs_pkg::ST_STRB &&
                                    kind_q == pfs_pkg::ACC_DWR);
      end
   end
   // ---------------------------------------------------------------
   // answer to the core
   // ---------------------------------------------------------------
   // the external byte is taken in the done state: the pin synchroniser
   // runs two cycles behind, which lands the sample inside the strobe
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy  <= 1'b0;
         done  <= 1'b0;
         rdata <= 8'h00;
      end else begin
         busy <= (st_q != pfs_pkg::ST_IDLE) || take;
         done <= (st_q == pfs_pkg::ST_DONE);
         if (st_q == pfs_pkg::ST_DONE) begin
            rdata <= int_q ? rom_data : port_in_s;
         end
      end
   end
endmodule
`default_nettype wire
